//--- triple_timer_counter_tb.sv
// Self-checking bench for the triple timer/counter
`timescale 1ns/1ps

module triple_timer_counter_tb;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        extIrqAPin = 1'b0;
    logic [3:0]  fire = 4'h0;
    logic [3:0]  pins;
    logic [3:0]  flags;
    logic        rxTick;
    logic        txTick;
    int          error_cnt = 0;
    int          checked = 0;
    int          rxCnt = 0;

    ttc_core dut (.clk_sys, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .countPinA(pins[0]),
        .countPinB(pins[1]), .eventPinC(pins[2]), .triggerPin(pins[3]), .extIrqAPin,
        .extIrqBPin(1'b1), .timerAOvfFlag(flags[0]), .timerBOvfFlag(flags[1]),
        .timerCOvfFlag(flags[2]), .timerCExtFlag(flags[3]), .rxBaudTick(rxTick),
        .txBaudTick(txTick));
    ttc_pin_model model (.clk_sys, .fireReq(fire), .pinLevel(pins));

    // Clock and baud tick counter
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (rxTick === 1'b1 && txTick === 1'b1) rxCnt++;

    //************************************************************************
    // Bus and check tasks
    //************************************************************************
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask : cmp

    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata[7:0];
        if (n >= 50) error_cnt++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        cmp(q, e);
    endtask : rd

    task automatic fl(input int i, input logic e);
        @(negedge clk_sys);
        cmp({7'h0, flags[i]}, {7'h0, e});
        @(posedge clk_sys);
    endtask : fl

    task automatic pulse(input logic [3:0] m);
        fire <= m;
        @(posedge clk_sys);
        fire <= 4'h0;
        repeat (60) @(posedge clk_sys);
    endtask : pulse

    //************************************************************************
    // Scenarios
    //************************************************************************
    task automatic t_basic;
        rd(ttc_pkg::REG_C_CTRL, 8'h00);
        rd(6'h2C, 8'h00);
        wr(ttc_pkg::REG_MODE, 8'h00);
        wr(ttc_pkg::REG_A_LOW, 8'hFE);
        wr(ttc_pkg::REG_A_HIGH, 8'hFF);
        wr(ttc_pkg::REG_CTRL, 8'h10);
        repeat (30) @(posedge clk_sys);
        fl(0, 1'b1);
        rd(ttc_pkg::REG_A_HIGH, 8'h00);
        wr(ttc_pkg::REG_CTRL, 8'h00);
        fl(0, 1'b0);
    endtask : t_basic

    task automatic t_hold;
        wr(ttc_pkg::REG_A_LOW, 8'hFF);
        wr(ttc_pkg::REG_A_HIGH, 8'hFF);
        wr(ttc_pkg::REG_B_LOW, 8'h00);
        wr(ttc_pkg::REG_MODE, 8'h39);
        wr(ttc_pkg::REG_CTRL, 8'h50);
        repeat (40) @(posedge clk_sys);
        rd(ttc_pkg::REG_A_LOW, 8'hFF);
        rd(ttc_pkg::REG_B_LOW, 8'h00);
        extIrqAPin <= 1'b1;
        repeat (30) @(posedge clk_sys);
        fl(0, 1'b1);
        wr(ttc_pkg::REG_CTRL, 8'h00);
    endtask : t_hold

    task automatic t_count;
        wr(ttc_pkg::REG_MODE, 8'h03);
        wr(ttc_pkg::REG_A_HIGH, 8'hFF);
        wr(ttc_pkg::REG_CTRL, 8'h40);
        repeat (20) @(posedge clk_sys);
        fl(1, 1'b1);
        wr(ttc_pkg::REG_CTRL, 8'h00);
        wr(ttc_pkg::REG_MODE, 8'h60);
        wr(ttc_pkg::REG_B_HIGH, 8'h80);
        wr(ttc_pkg::REG_B_LOW, 8'hFF);
        wr(ttc_pkg::REG_CTRL, 8'h40);
        pulse(4'h2);
        rd(ttc_pkg::REG_B_LOW, 8'h80);
        fl(1, 1'b1);
        wr(ttc_pkg::REG_CTRL, 8'h00);
    endtask : t_count

    task automatic t_timer_c;
        wr(ttc_pkg::REG_CAP_LO, 8'h34);
        wr(ttc_pkg::REG_CAP_HI, 8'h12);
        wr(ttc_pkg::REG_C_LOW, 8'hFE);
        wr(ttc_pkg::REG_C_HIGH, 8'hFF);
        wr(ttc_pkg::REG_C_CTRL, 8'h04);
        repeat (30) @(posedge clk_sys);
        rd(ttc_pkg::REG_C_HIGH, 8'h12);
        fl(2, 1'b1);
        wr(ttc_pkg::REG_C_CTRL, 8'h05);
        pulse(4'h8);
        fl(3, 1'b0);
        wr(ttc_pkg::REG_C_CTRL, 8'h0D);
        pulse(4'h8);
        fl(3, 1'b1);
        wr(ttc_pkg::REG_C_LOW, 8'hFE);
        wr(ttc_pkg::REG_C_HIGH, 8'hFF);
        rxCnt = 0;
        wr(ttc_pkg::REG_C_CTRL, 8'h34);
        repeat (40) @(posedge clk_sys);
        cmp({7'h0, rxCnt != 0}, 8'h01);
        fl(2, 1'b0);
        rd(ttc_pkg::REG_C_HIGH, 8'h12);
        wr(ttc_pkg::REG_C_CTRL, 8'h06);
        wr(ttc_pkg::REG_C_LOW, 8'h00);
        pulse(4'h4);
        rd(ttc_pkg::REG_C_LOW, 8'h01);
    endtask : t_timer_c

    task automatic wrap_up;
        if (error_cnt == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up

    // Main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        t_basic;
        t_hold;
        t_count;
        t_timer_c;
        wrap_up;
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        wrap_up;
    end

endmodule : triple_timer_counter_tb

//--- ttc_core.sv
// Triple timer/counter with Avalon-MM register access
`timescale 1ns/1ps

module ttc_core (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        countPinA,
    input  wire logic        countPinB,
    input  wire logic        eventPinC,
    input  wire logic        triggerPin,
    input  wire logic        extIrqAPin,
    input  wire logic        extIrqBPin,
    output logic             timerAOvfFlag,
    output logic             timerBOvfFlag,
    output logic             timerCOvfFlag,
    output logic             timerCExtFlag,
    output logic             rxBaudTick,
    output logic             txBaudTick
);
    //************************************************************************
    // Declarations
    //************************************************************************
    logic       ackQ;
    logic       busWr;
    logic [7:0] wd;
    logic [7:0] rdMux;
    logic [3:0] mcQ;
    logic       sampleTick;
    logic       updTick;
    logic       irqALvl, irqBLvl;
    logic       fallA, fallB, fallC, fallT;
    logic       pendAQ, pendBQ, pendCQ;
    logic       runAQ, runBQ, ovfAQ, ovfBQ;
    logic [7:0] tmodQ;
    logic [7:0] aLowQ, aHighQ, bLowQ, bHighQ;
    logic [7:0] cLowQ, cHighQ, capLowQ, capHighQ;
    logic [5:0] cCfgQ;
    logic       ovfCQ, extCQ;

    ttc_pkg::ttc_mode_t modeA, modeB;
    logic [16:0] stepA, stepB;
    logic        tickA, tickAH, tickB, bOvfEv;
    logic        cRun, baud, capMode, tickC, cOvf, trigC, reload, capture;
    logic [16:0] cNext;

    //************************************************************************
    // Avalon-MM slave: one wait cycle, then answer
    //************************************************************************

    // Wait state is cleared on the second cycle of every request
    assign avs_waitrequest = (avs_read | avs_write) & ~ackQ;
    assign busWr           = avs_write & ackQ & avs_byteenable[0];
    assign wd              = avs_writedata[7:0];

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ackQ <= 1'b0;
        end else begin
            ackQ <= (avs_read | avs_write) & ~ackQ;
        end
    end

    // Write strobe for one register
    function automatic logic wrHit(logic [5:0] off);
        return busWr && (avs_address == off);
    endfunction : wrHit

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        unique case (avs_address)
            ttc_pkg::REG_CTRL:   rdMux = {ovfBQ, runBQ, ovfAQ, runAQ, 4'h0};
            ttc_pkg::REG_MODE:   rdMux = tmodQ;
            ttc_pkg::REG_A_LOW:  rdMux = aLowQ;
            ttc_pkg::REG_A_HIGH: rdMux = aHighQ;
            ttc_pkg::REG_B_LOW:  rdMux = bLowQ;
            ttc_pkg::REG_B_HIGH: rdMux = bHighQ;
            ttc_pkg::REG_C_CTRL: rdMux = {ovfCQ, extCQ, cCfgQ}; // RULE14
            ttc_pkg::REG_C_LOW:  rdMux = cLowQ;
            ttc_pkg::REG_C_HIGH: rdMux = cHighQ;
            ttc_pkg::REG_CAP_LO: rdMux = capLowQ;
            ttc_pkg::REG_CAP_HI: rdMux = capHighQ;
            default:             rdMux = 8'h00;
        endcase
    end

    // Read data captured in the wait cycle, valid while waitrequest is low
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !ackQ) begin
            avs_readdata <= {24'h0, rdMux};
        end
    end

    //************************************************************************
    // Machine cycle and pin sampling
    //************************************************************************

    // Twelve clocks per machine cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mcQ <= 4'h0;
        end else begin
            mcQ <= (mcQ == ttc_pkg::MC_LAST) ? 4'h0 : mcQ + 4'h1; // RULE1
        end
    end

    assign sampleTick = (mcQ == ttc_pkg::SAMPLE_PHASE);
    assign updTick    = (mcQ == ttc_pkg::UPDATE_PHASE);

    ttc_pin_sampler u_smpA (.clk_sys(clk_sys), .reset_n(reset_n), .pinIn(countPinA),
        .sampleTick(sampleTick), .pinLevel(), .fallSeen(fallA));
    ttc_pin_sampler u_smpB (.clk_sys(clk_sys), .reset_n(reset_n), .pinIn(countPinB),
        .sampleTick(sampleTick), .pinLevel(), .fallSeen(fallB));
    ttc_pin_sampler u_smpC (.clk_sys(clk_sys), .reset_n(reset_n), .pinIn(eventPinC),
        .sampleTick(sampleTick), .pinLevel(), .fallSeen(fallC));
    ttc_pin_sampler u_smpT (.clk_sys(clk_sys), .reset_n(reset_n), .pinIn(triggerPin),
        .sampleTick(sampleTick), .pinLevel(), .fallSeen(fallT));
    ttc_pin_sampler u_smpIA (.clk_sys(clk_sys), .reset_n(reset_n), .pinIn(extIrqAPin),
        .sampleTick(sampleTick), .pinLevel(irqALvl), .fallSeen());
    ttc_pin_sampler u_smpIB (.clk_sys(clk_sys), .reset_n(reset_n), .pinIn(extIrqBPin),
        .sampleTick(sampleTick), .pinLevel(irqBLvl), .fallSeen());

    // Detected edges wait for the update phase of the next machine cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pendAQ <= 1'b0;
            pendBQ <= 1'b0;
            pendCQ <= 1'b0;
        end else begin
            pendAQ <= fallA | (pendAQ & ~updTick); // RULE3
            pendBQ <= fallB | (pendBQ & ~updTick); // RULE3
            pendCQ <= fallC | (pendCQ & ~updTick); // RULE3
        end
    end

    //************************************************************************
    // Timer A and timer B
    //************************************************************************

    assign modeA = ttc_pkg::ttc_mode_t'(tmodQ[ttc_pkg::MOD_M_A +: 2]); // RULE4
    assign modeB = ttc_pkg::ttc_mode_t'(tmodQ[ttc_pkg::MOD_M_B +: 2]); // RULE4
    assign stepA = ttc_pkg::ttc_step(modeA, {aHighQ, aLowQ}); // RULE5
    assign stepB = ttc_pkg::ttc_step(modeB, {bHighQ, bLowQ}); // RULE5

    // Count enables: run, pin qualify, source
    assign tickA = updTick & runAQ
                 & (~tmodQ[ttc_pkg::MOD_GATE_A] | irqALvl)       // RULE7 RULE8
                 & (~tmodQ[ttc_pkg::MOD_CT_A] | pendAQ);         // RULE2
    assign tickAH = updTick & runBQ & (modeA == ttc_pkg::TTC_M3); // RULE12
    assign tickB = updTick & runBQ
                 & (~tmodQ[ttc_pkg::MOD_GATE_B] | irqBLvl)       // RULE7 RULE8
                 & (~tmodQ[ttc_pkg::MOD_CT_B] | pendBQ)          // RULE2
                 & (modeB != ttc_pkg::TTC_M3);                   // RULE11 RULE13
    assign bOvfEv = tickB & stepB[16];

    // Mode register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tmodQ <= ttc_pkg::RESET_BYTE;
        end else if (wrHit(ttc_pkg::REG_MODE)) begin
            tmodQ <= wd;
        end
    end

    // Run bits; writing them leaves the counts alone
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            runAQ <= 1'b0;
            runBQ <= 1'b0;
        end else if (wrHit(ttc_pkg::REG_CTRL)) begin
            runAQ <= wd[ttc_pkg::CTL_RUN_A]; // RULE7
            runBQ <= wd[ttc_pkg::CTL_RUN_B];
        end
    end

    // Overflow flags; a hardware set wins over a software clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ovfAQ <= 1'b0;
            ovfBQ <= 1'b0;
        end else begin
            ovfAQ <= (tickA & stepA[16])                          // RULE6 RULE9 RULE10
                   | (wrHit(ttc_pkg::REG_CTRL) ? wd[ttc_pkg::CTL_OVF_A] : ovfAQ);
            ovfBQ <= (tickAH & (&aHighQ))                         // RULE12
                   | (bOvfEv & (modeA != ttc_pkg::TTC_M3))        // RULE13
                   | (wrHit(ttc_pkg::REG_CTRL) ? wd[ttc_pkg::CTL_OVF_B] : ovfBQ);
        end
    end

    // Timer A low byte
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            aLowQ <= ttc_pkg::RESET_BYTE;
        end else if (wrHit(ttc_pkg::REG_A_LOW)) begin
            aLowQ <= wd;
        end else if (tickA) begin
            aLowQ <= stepA[7:0]; // RULE10 RULE12
        end
    end

    // Timer A high byte; in mode 3 a plain machine cycle counter
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            aHighQ <= ttc_pkg::RESET_BYTE;
        end else if (wrHit(ttc_pkg::REG_A_HIGH)) begin
            aHighQ <= wd;
        end else if (tickAH) begin
            aHighQ <= aHighQ + 8'h1; // RULE12
        end else if (tickA && modeA != ttc_pkg::TTC_M3) begin
            aHighQ <= stepA[15:8]; // RULE9
        end
    end

    // Timer B low byte
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bLowQ <= ttc_pkg::RESET_BYTE;
        end else if (wrHit(ttc_pkg::REG_B_LOW)) begin
            bLowQ <= wd;
        end else if (tickB) begin
            bLowQ <= stepB[7:0]; // RULE10
        end
    end

    // Timer B high byte
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bHighQ <= ttc_pkg::RESET_BYTE;
        end else if (wrHit(ttc_pkg::REG_B_HIGH)) begin
            bHighQ <= wd;
        end else if (tickB) begin
            bHighQ <= stepB[15:8]; // RULE9
        end
    end

    //************************************************************************
    // Timer C
    //************************************************************************

    assign cRun    = cCfgQ[ttc_pkg::CC_RUN];
    assign baud    = cCfgQ[ttc_pkg::CC_RXB] | cCfgQ[ttc_pkg::CC_TXB];
    assign capMode = cCfgQ[ttc_pkg::CC_CAP] & ~baud;                    // RULE22
    assign tickC   = updTick & cRun                                     // RULE15
                   & (~cCfgQ[ttc_pkg::CC_SRC] | pendCQ);                // RULE16
    assign cNext   = {1'b0, cHighQ, cLowQ} + 17'h1;
    assign cOvf    = tickC & cNext[16];
    assign trigC   = fallT & cCfgQ[ttc_pkg::CC_TRG] & cRun;             // RULE21
    assign reload  = (cOvf & ~capMode) | (trigC & ~capMode & ~baud);    // RULE17 RULE20
    assign capture = trigC & capMode;                                   // RULE19

    // Configuration bits of timer_c_control_reg
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cCfgQ <= 6'h00;
        end else if (wrHit(ttc_pkg::REG_C_CTRL)) begin
            cCfgQ <= wd[5:0]; // RULE14
        end
    end

    // Timer C flags; sticky until software writes zero, set wins
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ovfCQ <= 1'b0;
            extCQ <= 1'b0;
        end else begin
            ovfCQ <= (cOvf & ~baud)                                 // RULE18 RULE24
                   | (wrHit(ttc_pkg::REG_C_CTRL) ? wd[ttc_pkg::CC_OVF] : ovfCQ);
            extCQ <= trigC                                          // RULE19 RULE20
                   | (wrHit(ttc_pkg::REG_C_CTRL) ? wd[ttc_pkg::CC_EXT] : extCQ);
        end
    end

    // Timer C count, reloaded from the capture pair
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cLowQ  <= ttc_pkg::RESET_BYTE;
            cHighQ <= ttc_pkg::RESET_BYTE;
        end else begin
            if (wrHit(ttc_pkg::REG_C_LOW)) begin
                cLowQ <= wd;
            end else if (reload) begin
                cLowQ <= capLowQ; // RULE20 RULE22
            end else if (tickC) begin
                cLowQ <= cNext[7:0];
            end
            if (wrHit(ttc_pkg::REG_C_HIGH)) begin
                cHighQ <= wd;
            end else if (reload) begin
                cHighQ <= capHighQ; // RULE20
            end else if (tickC) begin
                cHighQ <= cNext[15:8];
            end
        end
    end

    // Capture pair, written by software or by a trigger in capture mode
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            capLowQ  <= ttc_pkg::RESET_BYTE;
            capHighQ <= ttc_pkg::RESET_BYTE;
        end else begin
            if (wrHit(ttc_pkg::REG_CAP_LO)) begin
                capLowQ <= wd;
            end else if (capture) begin
                capLowQ <= cLowQ; // RULE19
            end
            if (wrHit(ttc_pkg::REG_CAP_HI)) begin
                capHighQ <= wd;
            end else if (capture) begin
                capHighQ <= cHighQ; // RULE19
            end
        end
    end

    // Serial clock pulses from timer C or timer B overflows
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rxBaudTick <= 1'b0;
            txBaudTick <= 1'b0;
        end else begin
            rxBaudTick <= cCfgQ[ttc_pkg::CC_RXB] ? cOvf : bOvfEv; // RULE25 RULE13
            txBaudTick <= cCfgQ[ttc_pkg::CC_TXB] ? cOvf : bOvfEv; // RULE25
        end
    end

    // Flags to the interrupt logic
    assign timerAOvfFlag = ovfAQ;
    assign timerBOvfFlag = ovfBQ;
    assign timerCOvfFlag = ovfCQ;
    assign timerCExtFlag = extCQ; // RULE23

    //************************************************************************
    // Assertions
    //************************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    mc_period_a: assert property ( // RULE1
        updTick |-> ##12 updTick)
        else $error("machine cycle is not twelve clocks");

    edge_latency_a: assert property ( // RULE3
        $rose(pendBQ) |-> !updTick ##1 !updTick ##1 !updTick ##1 updTick)
        else $error("count edge not applied in following machine cycle");

    a_wrap_flag_a: assert property ( // RULE6
        (tickA && modeA == ttc_pkg::TTC_M13 && (&{aHighQ, aLowQ[4:0]})) |=> ovfAQ)
        else $error("13-bit rollover did not set flag");

    a_idle_hold_a: assert property ( // RULE7
        (updTick && !runAQ && modeA != ttc_pkg::TTC_M3 && !busWr) |=> $stable(aLowQ))
        else $error("timer A counted while stopped");

    a_sixteen_a: assert property ( // RULE9
        (tickA && modeA == ttc_pkg::TTC_M16 && !busWr)
        |=> {aHighQ, aLowQ} == $past({aHighQ, aLowQ}) + 16'h1)
        else $error("16-bit count step wrong");

    b_reload_a: assert property ( // RULE10
        (tickB && modeB == ttc_pkg::TTC_M8R && (&bLowQ) && !busWr && modeA != ttc_pkg::TTC_M3)
        |=> bLowQ == $past(bHighQ) && $stable(bHighQ) && ovfBQ)
        else $error("8-bit reload wrong");

    b_mode3_hold_a: assert property ( // RULE11
        (modeB == ttc_pkg::TTC_M3 && !busWr) |=> $stable({bHighQ, bLowQ}))
        else $error("timer B moved in mode 3");

    c_off_hold_a: assert property ( // RULE15
        (!cRun && !busWr) |=> $stable({cHighQ, cLowQ}))
        else $error("timer C counted while off");

    c_capture_a: assert property ( // RULE19
        (capture && !busWr)
        |=> capLowQ == $past(cLowQ) && capHighQ == $past(cHighQ) && extCQ)
        else $error("capture did not copy count");

    baud_no_flag_a: assert property ( // RULE24
        (cOvf && baud && !ovfCQ && !busWr) |=> !ovfCQ)
        else $error("baud overflow set timer C flag");

endmodule : ttc_core

//--- ttc_pin_model.sv
// Far-side model driving the count, event and trigger pins with held levels
`timescale 1ns/1ps

module ttc_pin_model (
    input  wire logic       clk_sys,
    input  wire logic [3:0] fireReq,
    output logic      [3:0] pinLevel
);
    logic [5:0] holdQ = 6'h00;
    logic [3:0] maskQ = 4'h0;

    // A request drops the chosen pins for two machine cycles, then idles high as long
    always_ff @(posedge clk_sys) begin
        if (holdQ != 6'h00) begin
            holdQ <= holdQ - 6'h01;
        end else if (fireReq != 4'h0) begin
            holdQ <= 6'h30;
            maskQ <= fireReq;
        end
    end

    // Each level stands 24 clocks, well above one machine cycle plus sync
    assign pinLevel = (holdQ > 6'h18) ? ~maskQ : 4'hF;

endmodule : ttc_pin_model

//--- ttc_pin_sampler.sv
// Pin synchroniser and once-per-machine-cycle falling edge sampler
`timescale 1ns/1ps

module ttc_pin_sampler (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic pinIn,
    input  wire logic sampleTick,
    output logic      pinLevel,
    output logic      fallSeen
);
    logic [1:0] syncQ;
    logic       sampQ;

    // Two flops before anything looks at the pin
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            syncQ <= 2'h0;
        end else begin
            syncQ <= {syncQ[0], pinIn};
        end
    end

    // One sample per machine cycle; high then low gives one pulse
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sampQ    <= 1'b0;
            fallSeen <= 1'b0;
        end else begin
            fallSeen <= sampleTick & sampQ & ~syncQ[1]; // RULE2
            if (sampleTick) begin
                sampQ <= syncQ[1];
            end
        end
    end

    assign pinLevel = syncQ[1];

endmodule : ttc_pin_sampler

//--- ttc_pkg.sv
// Constants, types and shared arithmetic for the triple timer/counter
//****************************************************************************
// What this block does
// RULE1: Timer function increments once per machine cycle of twelve clock periods.
// RULE2: Count pins are sampled once per machine cycle; high then low counts one.
// RULE3: A detected count edge shows in the counter in the following machine cycle.
// RULE4: Mode field: 00 13-bit, 01 16-bit, 10 8-bit reload, 11 split or stop.
// RULE5: 13-bit mode uses high byte plus low five bits of low byte.
// RULE6: 13-bit rollover from all ones to zero sets the overflow flag.
// RULE7: Counting needs run set and either qualify clear or interrupt pin high.
// RULE8: Qualify bits sit at mode register bit 7 for B, bit 3 for A.
// RULE9: 16-bit mode counts across both bytes, flags on wrap, keeps counting.
// RULE10: 8-bit reload mode flags low byte overflow and reloads it from high byte.
// RULE11: Timer B in mode 3 holds its count as if stopped.
// RULE12: Timer A mode 3: low byte uses A controls; high byte uses B run and flag.
// RULE13: With A in mode 3, B runs outside its mode 3 and still feeds baud.
// RULE14: Timer C control bits from 7: flags, baud selects, trigger, run, source, capture.
// RULE15: Timer C runs only while its run bit is one.
// RULE16: Timer C source: zero counts machine cycles, one counts event pin falls.
// RULE17: Timer C mode: reload, capture, or baud generator when either baud select set.
// RULE18: Timer C overflow in capture or reload mode sets its overflow flag.
// RULE19: Capture mode trigger fall copies count into capture pair, sets external flag.
// RULE20: Reload mode reloads on rollover, and on trigger fall when trigger enabled.
// RULE21: With trigger enable clear, timer C ignores the trigger pin.
// RULE22: With a baud select set, capture bit is ignored and overflow reloads.
// RULE23: Timer C external flag raises an interrupt request like the overflow flag.
// RULE24: Baud mode never sets overflow flag; both timer C flags stay until cleared.
// RULE25: Baud selects route timer C overflows, else timer B overflows, to serial clocks.
//****************************************************************************

package ttc_pkg;

    // Machine cycle phases, counted in clk_sys periods
    localparam logic [3:0] MC_LAST      = 4'hB;
    localparam logic [3:0] SAMPLE_PHASE = 4'h9;
    localparam logic [3:0] UPDATE_PHASE = 4'h2;

    // Register byte offsets
    localparam logic [5:0] REG_CTRL   = 6'h00;
    localparam logic [5:0] REG_MODE   = 6'h04;
    localparam logic [5:0] REG_A_LOW  = 6'h08;
    localparam logic [5:0] REG_A_HIGH = 6'h0C;
    localparam logic [5:0] REG_B_LOW  = 6'h10;
    localparam logic [5:0] REG_B_HIGH = 6'h14;
    localparam logic [5:0] REG_C_CTRL = 6'h18;
    localparam logic [5:0] REG_C_LOW  = 6'h1C;
    localparam logic [5:0] REG_C_HIGH = 6'h20;
    localparam logic [5:0] REG_CAP_LO = 6'h24;
    localparam logic [5:0] REG_CAP_HI = 6'h28;

    // timer_ctrl_reg fields
    localparam int CTL_OVF_B = 7;
    localparam int CTL_RUN_B = 6;
    localparam int CTL_OVF_A = 5;
    localparam int CTL_RUN_A = 4;

    // timer_mode_reg fields
    localparam int MOD_GATE_B = 7;
    localparam int MOD_CT_B   = 6;
    localparam int MOD_M_B    = 4;
    localparam int MOD_GATE_A = 3;
    localparam int MOD_CT_A   = 2;
    localparam int MOD_M_A    = 0;

    // timer_c_control_reg fields
    localparam int CC_OVF = 7;
    localparam int CC_EXT = 6;
    localparam int CC_RXB = 5;
    localparam int CC_TXB = 4;
    localparam int CC_TRG = 3;
    localparam int CC_RUN = 2;
    localparam int CC_SRC = 1;
    localparam int CC_CAP = 0;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef enum logic [1:0] {
        TTC_M13 = 2'h0,
        TTC_M16 = 2'h1,
        TTC_M8R = 2'h2,
        TTC_M3  = 2'h3
    } ttc_mode_t;

    // One count step of timer A or B; bit 16 is the overflow
    function automatic logic [16:0] ttc_step(ttc_mode_t m, logic [15:0] v);
        logic [16:0] r;
        r = {1'b0, v};
        unique case (m)
            TTC_M13: begin
                r[4:0]  = v[4:0] + 5'h1;
                r[15:8] = v[15:8] + {7'h0, &v[4:0]};
                r[16]   = &{v[15:8], v[4:0]};
            end
            TTC_M16: begin
                r = {1'b0, v} + 17'h1;
            end
            TTC_M8R: begin
                r[7:0] = (&v[7:0]) ? v[15:8] : v[7:0] + 8'h1;
                r[16]  = &v[7:0];
            end
            TTC_M3: begin
                r[7:0] = v[7:0] + 8'h1;
                r[16]  = &v[7:0];
            end
        endcase
        return r;
    endfunction : ttc_step

endpackage : ttc_pkg
